/* File: inc/ftb_pkg.sv */
// Purpose: shared constants for the flow totalizer with batch control
// Assumes: 10 MHz system clock, AHB-Lite register access
// Notes: offsets are byte addresses of 32-bit words
package ftb_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RATE = 8'h04;
    localparam logic [7:0] OFS_TARGET = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0c;
    localparam logic [7:0] OFS_TOTAL = 8'h10;
    localparam logic [7:0] OFS_HOURS = 8'h14;
    localparam logic [7:0] OFS_MINSEC = 8'h18;
    localparam logic [7:0] OFS_PEAK = 8'h1c;
    localparam logic [7:0] OFS_REMAIN = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    // batch quantity register number 92, four bytes per word
    localparam int unsigned BATCH_REG_NUM = 92;
    localparam logic [9:0] OFS_BATCH = 10'(BATCH_REG_NUM * 4);
    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int CTRL_POL_LSB = 0;
    localparam int CTRL_RES_LSB = 2;
    localparam int CTRL_METER_BIT = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
    localparam int CMD_PANEL_CLR = 0;
    localparam int CMD_SERIAL_CLR = 1;
    localparam int CMD_VIEW_TOGGLE = 2;
    localparam int CMD_TARGET_COMMIT = 3;
    localparam int CMD_BATCH_COMMIT = 4;
    // ------------------------------------------------------------
    // counts
    // ------------------------------------------------------------
    localparam logic [26:0] TOTAL_MAX = 27'd9999999;
    localparam logic [13:0] HOURS_MAX = 14'd9999;
    localparam logic [5:0] MINSEC_MAX = 6'd59;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned SEC_MS = 1000;
    localparam int unsigned SEC_CYC = CLK_HZ / 1000 * SEC_MS;
    localparam int unsigned SAMPLE_MS = 10;
    localparam int unsigned SAMPLE_CYC = CLK_HZ / 1000 * SAMPLE_MS;
    // residue scale: rate units per count at each resolution
    localparam logic [15:0] SCALE_0 = 16'd1;
    localparam logic [15:0] SCALE_1 = 16'd10;
    localparam logic [15:0] SCALE_2 = 16'd100;
    localparam logic [15:0] SCALE_3 = 16'd1000;

    typedef enum logic [1:0] {
        POL_STOP = 2'b00,
        POL_WRAP = 2'b01,
        POL_WRAP_NOTE = 2'b10
    } ftb_pol_t;

    typedef enum logic [1:0] {
        BST_OFF = 2'b00,
        BST_RUN = 2'b01,
        BST_WAIT = 2'b10,
        BST_DONE = 2'b11
    } ftb_bst_t;
endpackage

/* File: logic/ftb_top.sv */
// Purpose: flow totalizer with elapsed timer, peak hold and batch control
// Assumes: measured rate arrives synchronous to CLK; AHB-Lite slave
// Notes: batch quantity is kept outside power-on reset
// Behaviour
// - no-rollover policy freezes total at maximum
// - plain rollover wraps total silently
// - notified rollover wraps and flags overflow
// - total seven digits, resolution sets weight
// - elapsed h:m:s saturating at 9999:59:59
// - panel, serial clear or power clears timer
// - meter holds peak rate until clear
// - panel reset clears total any time
// - view key swaps total and time display
// - batch commit starts flow if target nonzero
// - host writes batch quantity at register 92
// - batch quantity survives power cycle
// - show remaining quantity and batch time
// - at batch quantity stop flow, done, pause
// - reset after done starts same batch again
// - raised batch after done resumes flow
// - zero target committed halts batch
// - flow rate follows target, batch gates only
// - zero batch disables batch mode
`timescale 1ns/1ns
module ftb_top (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // flow path
    input wire logic [15:0] FLOW_RATE,
    output logic [15:0] FLOW_DEMAND,
    output logic FLOW_ENABLE,
    // display state
    output logic VIEW_TIME,
    output logic BATCH_DONE,
    output logic OVERFLOW_ERR
);
    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic wr_pend_q;
    logic [9:0] addr_q;
    logic [31:0] ctrl_q;
    logic [15:0] target_q;
    logic [26:0] batch_q;
    logic [26:0] total_q, total_d;
    logic [13:0] hours_q;
    logic [5:0] min_q, sec_q;
    logic [15:0] peak_q;
    logic [15:0] resid_q, resid_d;
    logic [23:0] sec_cnt_q;
    logic [23:0] smp_cnt_q;
    logic view_q, ovf_q;
    logic batch_wr_q;
    ftb_pkg::ftb_bst_t bst_q, bst_d;

    wire addr_ok = HSEL & HREADY & HTRANS[1];
    wire do_wr = wr_pend_q;
    wire [4:0] cmd_w = do_wr && addr_q == 10'(ftb_pkg::OFS_CMD) ?
        HWDATA[4:0] : 5'h00;
    wire clr = cmd_w[ftb_pkg::CMD_PANEL_CLR] |
        cmd_w[ftb_pkg::CMD_SERIAL_CLR];
    wire tgt_commit = cmd_w[ftb_pkg::CMD_TARGET_COMMIT];
    wire batch_wr = do_wr && addr_q == ftb_pkg::OFS_BATCH;
    wire batch_commit = batch_wr | batch_wr_q |
        cmd_w[ftb_pkg::CMD_BATCH_COMMIT];
    wire [1:0] pol = ctrl_q[ftb_pkg::CTRL_POL_LSB +: 2];
    wire [1:0] res = ctrl_q[ftb_pkg::CTRL_RES_LSB +: 2];
    wire meter = ctrl_q[ftb_pkg::CTRL_METER_BIT];
    wire [26:0] remain = batch_q > total_q ? batch_q - total_q : 27'd0;

    // address phase captured, writes land in data phase
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            wr_pend_q <= 1'b0;
            addr_q <= 10'h000;
        end else begin
            wr_pend_q <= addr_ok & HWRITE;
            if (addr_ok) begin
                addr_q <= HADDR[9:0];
            end
        end
    end

    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // read mux; unmapped words read zero
    logic [31:0] rd_w;
    always_comb begin
        case (HADDR[9:0])
            10'(ftb_pkg::OFS_CTRL): rd_w = ctrl_q;
            10'(ftb_pkg::OFS_RATE): rd_w = {16'h0000, FLOW_RATE};
            10'(ftb_pkg::OFS_TARGET): rd_w = {16'h0000, target_q};
            10'(ftb_pkg::OFS_TOTAL): rd_w = {5'h00, total_q};
            10'(ftb_pkg::OFS_HOURS): rd_w = {18'h00000, hours_q};
            10'(ftb_pkg::OFS_MINSEC): rd_w = {20'h00000, min_q, sec_q};
            10'(ftb_pkg::OFS_PEAK): rd_w = {16'h0000, peak_q};
            10'(ftb_pkg::OFS_REMAIN): rd_w = {5'h00, remain};
            10'(ftb_pkg::OFS_STATUS):
                rd_w = {26'h0000000, bst_q, ovf_q, view_q, FLOW_ENABLE,
                    BATCH_DONE};
            ftb_pkg::OFS_BATCH: rd_w = {5'h00, batch_q};
            default: rd_w = 32'h0000_0000;
        endcase
    end

    // data register so read data stands through the data phase
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            HRDATA <= 32'h0000_0000;
        end else if (addr_ok & ~HWRITE) begin
            HRDATA <= rd_w;
        end
    end

    // ------------------------------------------------------------
    // software settings
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_q <= ftb_pkg::CTRL_RESET;
            target_q <= 16'h0000;
            view_q <= 1'b0;
        end else begin
            if (do_wr && addr_q == 10'(ftb_pkg::OFS_CTRL)) begin
                ctrl_q <= {27'h0000000, HWDATA[4:0]};
            end
            if (do_wr && addr_q == 10'(ftb_pkg::OFS_TARGET)) begin
                target_q <= HWDATA[15:0];
            end
            if (cmd_w[ftb_pkg::CMD_VIEW_TOGGLE]) begin
                view_q <= ~view_q;
            end
        end
    end

    // batch quantity has no power-on reset: models nonvolatile store
    always_ff @(posedge CLK) begin
        if (batch_wr) begin
            batch_q <= HWDATA[26:0];
        end
    end

    // ------------------------------------------------------------
    // tick generators
    // ------------------------------------------------------------
    wire smp_tick = smp_cnt_q == 24'(ftb_pkg::SAMPLE_CYC - 1);
    wire sec_tick = sec_cnt_q == 24'(ftb_pkg::SEC_CYC - 1);
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            smp_cnt_q <= 24'h000000;
            sec_cnt_q <= 24'h000000;
        end else begin
            smp_cnt_q <= smp_tick ? 24'h000000 : smp_cnt_q + 24'h000001;
            sec_cnt_q <= sec_tick | clr ? 24'h000000 :
                sec_cnt_q + 24'h000001;
        end
    end

    // ------------------------------------------------------------
    // batch state
    // ------------------------------------------------------------
    // a clear in this cycle means the total is already zero next cycle
    wire batch_on = batch_q != 27'd0;
    wire reached = batch_on && !clr && total_q >= batch_q;
    always_comb begin
        bst_d = bst_q;
        case (bst_q)
            ftb_pkg::BST_OFF,
            ftb_pkg::BST_RUN,
            ftb_pkg::BST_WAIT,
            ftb_pkg::BST_DONE: begin
                if (!batch_on) begin
                    bst_d = ftb_pkg::BST_OFF;
                end else if (reached) begin
                    bst_d = ftb_pkg::BST_DONE;
                end else if (target_q == 16'h0000) begin
                    bst_d = ftb_pkg::BST_WAIT;
                end else if (bst_q != ftb_pkg::BST_DONE || batch_commit ||
                    clr) begin
                    bst_d = ftb_pkg::BST_RUN;
                end
            end
            default: bst_d = ftb_pkg::BST_OFF;
        endcase
    end

    // a quantity write is seen again once batch_q holds it, so a
    // raised quantity after completion can leave the done state
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            batch_wr_q <= 1'b0;
        end else begin
            batch_wr_q <= batch_wr;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            bst_q <= ftb_pkg::BST_OFF;
        end else if (batch_commit | tgt_commit | clr | reached |
            !batch_on | bst_q == ftb_pkg::BST_RUN) begin
            bst_q <= bst_d;
        end
    end

    wire flowing = bst_q == ftb_pkg::BST_OFF || bst_q == ftb_pkg::BST_RUN;
    assign FLOW_ENABLE = flowing && target_q != 16'h0000;
    assign FLOW_DEMAND = FLOW_ENABLE ? target_q : 16'h0000;
    assign BATCH_DONE = bst_q == ftb_pkg::BST_DONE;
    assign VIEW_TIME = view_q;
    assign OVERFLOW_ERR = ovf_q;

    // ------------------------------------------------------------
    // totalizer
    // ------------------------------------------------------------
    logic [15:0] scale;
    always_comb begin
        case (res)
            2'b00: scale = ftb_pkg::SCALE_0;
            2'b01: scale = ftb_pkg::SCALE_1;
            2'b10: scale = ftb_pkg::SCALE_2;
            default: scale = ftb_pkg::SCALE_3;
        endcase
    end

    // residue stays below one count, so the sum fits 17 bits
    wire [16:0] acc = {1'b0, resid_q} + {1'b0, FLOW_RATE};

    // whole counts in this tick; dividers are constants per resolution
    logic [16:0] cnt;
    always_comb begin
        case (res)
            2'b00: cnt = acc / {1'b0, ftb_pkg::SCALE_0};
            2'b01: cnt = acc / {1'b0, ftb_pkg::SCALE_1};
            2'b10: cnt = acc / {1'b0, ftb_pkg::SCALE_2};
            default: cnt = acc / {1'b0, ftb_pkg::SCALE_3};
        endcase
    end

    // one tick adds far less than the full range, so at most one wrap
    wire [16:0] used = 17'(cnt * {1'b0, scale});
    wire [27:0] sum = {1'b0, total_q} + {11'h000, cnt};
    wire over = sum > {1'b0, ftb_pkg::TOTAL_MAX};
    wire [27:0] wrapped = sum - {1'b0, ftb_pkg::TOTAL_MAX} - 28'h0000001;
    logic wrap;
    always_comb begin
        total_d = total_q;
        resid_d = resid_q;
        wrap = 1'b0;
        if (smp_tick && !BATCH_DONE) begin
            resid_d = 16'(acc - used);
            if (!over) begin
                total_d = sum[26:0];
            end else if (pol != 2'(ftb_pkg::POL_STOP)) begin
                total_d = wrapped[26:0];
                wrap = 1'b1;
            end else begin
                total_d = ftb_pkg::TOTAL_MAX;
                resid_d = resid_q;
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            total_q <= 27'd0;
            resid_q <= 16'h0000;
            ovf_q <= 1'b0;
        end else begin
            total_q <= clr ? 27'd0 : total_d;
            resid_q <= clr ? 16'h0000 : resid_d;
            // a wrap in the clearing cycle still flags
            ovf_q <= (wrap && pol == 2'(ftb_pkg::POL_WRAP_NOTE)) |
                (ovf_q & ~clr);
        end
    end

    // ------------------------------------------------------------
    // peak hold, meter variants only
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            peak_q <= 16'h0000;
        end else if (clr) begin
            peak_q <= 16'h0000;
        end else if (meter && FLOW_RATE > peak_q) begin
            peak_q <= FLOW_RATE;
        end
    end

    // ------------------------------------------------------------
    // elapsed timer
    // ------------------------------------------------------------
    logic sec_last, min_last;
    wire t_full = hours_q == ftb_pkg::HOURS_MAX && min_last && sec_last;
    wire t_run = sec_tick && !t_full && !BATCH_DONE;
    wire min_step = t_run && sec_last;
    wire hour_step = min_step && min_last;

    // seconds digit pair
    ftb_wrap_cnt #(
        .WIDTH(6),
        .LAST(ftb_pkg::MINSEC_MAX)
    ) u_sec (
        .clk(CLK),
        .rst_n(RSTN),
        .clr(clr),
        .inc(t_run),
        .cnt_q(sec_q),
        .last(sec_last)
    );

    // minutes digit pair, stepped on the last second
    ftb_wrap_cnt #(
        .WIDTH(6),
        .LAST(ftb_pkg::MINSEC_MAX)
    ) u_min (
        .clk(CLK),
        .rst_n(RSTN),
        .clr(clr),
        .inc(min_step),
        .cnt_q(min_q),
        .last(min_last)
    );

    // hours never wrap: the full check holds them at the top
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            hours_q <= 14'd0;
        end else if (clr) begin
            hours_q <= 14'd0;
        end else if (hour_step) begin
            hours_q <= hours_q + 14'd1;
        end
    end
endmodule // ftb_top

// ------------------------------------------------------------
// wrapping digit counter
// ------------------------------------------------------------
module ftb_wrap_cnt #(
    parameter int WIDTH = 6,
    parameter logic [WIDTH-1:0] LAST = '1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // step control
    input wire logic clr,
    input wire logic inc,
    // count state
    output logic [WIDTH-1:0] cnt_q,
    output logic last
);
    assign last = cnt_q == LAST;

    // clear wins over a step landing in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (clr) begin
            cnt_q <= '0;
        end else if (inc) begin
            cnt_q <= last ? '0 : cnt_q + WIDTH'(1'b1);
        end
    end
endmodule // ftb_wrap_cnt

/* File: verification/ftb_host_model.sv */
// Purpose: serial host and panel keys as an ahb-lite master
// Assumes: one outstanding single word transfer
// Notes: read data is handed on by a counted strobe
`timescale 1ns/1ns
module ftb_host_model (
    // bus answer
    input logic clk,
    input logic hready,
    input logic [31:0] hrdata,
    // bus request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // results
    output logic [31:0] rd_value,
    output int rd_count,
    output logic hung
);
    // ----------------------------------------
    // transfer
    // ----------------------------------------
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata, rd_value, hung} = '0;
        hsize = 3'b010;
        rd_count = 0;
    end
    // hwdata flips outside its phase so stale data never matches
    task automatic xfer(input logic w, input logic [31:0] a, d);
        int n;
        n = 0;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hwdata <= ~hwdata;
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 20);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 40);
        if (n >= 40) hung <= 1'b1;
        rd_value <= hrdata;
        if (!w) rd_count <= rd_count + 1;
    endtask
    // address and clear characters decoded to a clear pulse
    task automatic serial_clear();
        xfer(1'b1, 32'(ftb_pkg::OFS_CMD), 32'h2);
    endtask
endmodule // ftb_host_model

/* File: verification/ftb_top_bench.sv */
// Purpose: self-checking bench for the flow totalizer
// Assumes: sample and second ticks too slow to reach here
// Notes: totalizing counts checked only as zero after a clear
`timescale 1ns/1ns
module ftb_top_bench;
    logic CLK, RSTN, HSEL, HWRITE, HREADYOUT, HRESP, FLOW_ENABLE;
    logic VIEW_TIME, BATCH_DONE, OVERFLOW_ERR, hung;
    logic [31:0] HADDR, HWDATA, HRDATA, rd_value, qty, ctl;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [15:0] FLOW_RATE, FLOW_DEMAND, tgt;
    logic [31:0] exp_q[$];
    int rd_count, bad_count, comparisons, seed;
    ftb_top u_dut (.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .FLOW_RATE(FLOW_RATE), .FLOW_DEMAND(FLOW_DEMAND),
        .FLOW_ENABLE(FLOW_ENABLE), .VIEW_TIME(VIEW_TIME),
        .BATCH_DONE(BATCH_DONE), .OVERFLOW_ERR(OVERFLOW_ERR));
    ftb_host_model u_host (.clk(CLK), .hready(HREADYOUT), .hrdata(HRDATA),
        .hsel(HSEL), .haddr(HADDR), .htrans(HTRANS), .hwrite(HWRITE),
        .hsize(HSIZE), .hwdata(HWDATA), .rd_value(rd_value),
        .rd_count(rd_count), .hung(hung));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("compared %0d, wrong %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic compare_word(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // pins are looked at half a cycle after the write lands
    task automatic compare_pin(input logic [15:0] got, exp);
        compare_word(32'(got), 32'(exp));
    endtask
    task automatic wr(input logic [31:0] a, d);
        u_host.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [31:0] a, e);
        exp_q.push_back(e);
        u_host.xfer(1'b0, a, 32'h0);
    endtask
    // monitor pops the oldest note for each read result
    always @(rd_count) begin
        #1;
        if (exp_q.size() > 0) compare_word(rd_value, exp_q.pop_front());
    end
    always @(posedge hung) begin
        bad_count++;
        tally_and_finish();
    end
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = 88605;
        RSTN = 1'b0;
        repeat (16) @(posedge CLK);
        RSTN <= 1'b1;
        FLOW_RATE <= 16'($random(seed));
        rd(32'(ftb_pkg::OFS_CTRL), ftb_pkg::CTRL_RESET);
        rd(32'(ftb_pkg::OFS_STATUS), 32'h0);
        rd(32'h28, 32'h0);
        ctl = {27'h0, 1'b1, 2'($random(seed)), 2'b10};
        wr(32'(ftb_pkg::OFS_CTRL), ctl);
        rd(32'(ftb_pkg::OFS_CTRL), ctl);
        $display("test reset_and_ctrl done");
        wr(32'(ftb_pkg::OFS_CMD), 32'h4);
        @(negedge CLK);
        compare_pin(16'(VIEW_TIME), 16'h1);
        rd(32'(ftb_pkg::OFS_STATUS), 32'h4);
        wr(32'(ftb_pkg::OFS_CMD), 32'h4);
        @(negedge CLK);
        compare_pin(16'(VIEW_TIME), 16'h0);
        $display("test view_toggle done");
        tgt = 16'($random(seed)) | 16'h0001;
        qty = 32'h1000 + 32'(12'($random(seed)));
        wr(32'(ftb_pkg::OFS_TARGET), 32'(tgt));
        wr(32'(ftb_pkg::OFS_CMD), 32'h8);
        wr(32'(ftb_pkg::OFS_BATCH), qty);
        @(negedge CLK);
        compare_pin(16'(FLOW_ENABLE), 16'h1);
        compare_pin(FLOW_DEMAND, tgt);
        rd(32'(ftb_pkg::OFS_REMAIN), qty);
        rd(32'(ftb_pkg::OFS_BATCH), qty);
        rd(32'(ftb_pkg::OFS_STATUS), 32'h12);
        $display("test batch_start done");
        wr(32'(ftb_pkg::OFS_TARGET), 32'h0);
        wr(32'(ftb_pkg::OFS_CMD), 32'h8);
        @(negedge CLK);
        compare_pin(FLOW_DEMAND, 16'h0);
        rd(32'(ftb_pkg::OFS_STATUS), 32'h20);
        wr(32'(ftb_pkg::OFS_TARGET), 32'(tgt));
        wr(32'(ftb_pkg::OFS_CMD), 32'h8);
        wr(32'(ftb_pkg::OFS_BATCH), 32'h0);
        @(negedge CLK);
        compare_pin(16'(FLOW_ENABLE), 16'h1);
        rd(32'(ftb_pkg::OFS_STATUS), 32'h02);
        $display("test batch_halt_and_off done");
        rd(32'(ftb_pkg::OFS_PEAK), {16'h0, FLOW_RATE});
        wr(32'(ftb_pkg::OFS_CMD), 32'h1);
        rd(32'(ftb_pkg::OFS_TOTAL), 32'h0);
        rd(32'(ftb_pkg::OFS_HOURS), 32'h0);
        u_host.serial_clear();
        rd(32'(ftb_pkg::OFS_MINSEC), 32'h0);
        $display("test clears done");
        repeat (4) @(posedge CLK);
        tally_and_finish();
    end
endmodule // ftb_top_bench
bind ftb_top ftb_top_checker u_chk (.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .FLOW_DEMAND(FLOW_DEMAND), .FLOW_ENABLE(FLOW_ENABLE),
    .VIEW_TIME(VIEW_TIME), .BATCH_DONE(BATCH_DONE),
    .OVERFLOW_ERR(OVERFLOW_ERR));

/* File: verification/ftb_top_checker.sv */
// Purpose: port-level assertions for the flow totalizer
// Assumes: zero-wait slave, single word transfers
// Notes: bound in the bench top file
`timescale 1ns/1ns
module ftb_top_checker (
    // clock and reset
    input logic CLK,
    input logic RSTN,
    // bus
    input logic HSEL,
    input logic [31:0] HADDR,
    input logic [1:0] HTRANS,
    input logic HWRITE,
    input logic [31:0] HWDATA,
    input logic HREADY,
    input logic [31:0] HRDATA,
    input logic HREADYOUT,
    input logic HRESP,
    // flow and display
    input logic [15:0] FLOW_DEMAND,
    input logic FLOW_ENABLE,
    input logic VIEW_TIME,
    input logic BATCH_DONE,
    input logic OVERFLOW_ERR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // ----------------------------------------
    // data phase tracking
    // ----------------------------------------
    logic dp_wr_q, dp_rd_q;
    logic [31:0] dp_addr_q, bq_q;
    logic [1:0] pol_q;
    wire take = HSEL & HREADY & HTRANS[1];
    // policy mirror follows the control writes
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            dp_wr_q <= 1'b0;
            dp_rd_q <= 1'b0;
            dp_addr_q <= 32'h0;
            pol_q <= 2'h0;
        end else begin
            dp_wr_q <= take & HWRITE;
            dp_rd_q <= take & ~HWRITE;
            if (take) begin
                dp_addr_q <= HADDR;
            end
            if (dp_wr_q && dp_addr_q == 32'(ftb_pkg::OFS_CTRL)) begin
                pol_q <= HWDATA[1:0];
            end
        end
    end
    // no reset: batch quantity survives power loss
    always_ff @(posedge CLK) begin
        if (dp_wr_q && dp_addr_q == 32'(ftb_pkg::OFS_BATCH)) begin
            bq_q <= HWDATA;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    AST_ZERO_WAIT: assert property (HREADYOUT == 1'b1 && HRESP == 1'b0)
        else $error("slave stalled or errored");
    AST_DEMAND_GATED: assert property (!FLOW_ENABLE |-> FLOW_DEMAND == 16'h0)
        else $error("demand while flow disabled");
    AST_ENABLE_DEMAND: assert property (FLOW_ENABLE |-> FLOW_DEMAND != 16'h0)
        else $error("flow enabled with zero demand");
    AST_DONE_STOPS: assert property (BATCH_DONE |-> !FLOW_ENABLE)
        else $error("flow runs after batch done");
    AST_VIEW_TOGGLE: assert property ((dp_wr_q && HWDATA[2]
        && dp_addr_q == 32'(ftb_pkg::OFS_CMD)) |=> VIEW_TIME != $past(VIEW_TIME))
        else $error("view key did not swap display");
    AST_BATCH_READ: assert property ((dp_rd_q
        && dp_addr_q == 32'(ftb_pkg::OFS_BATCH))
        |-> HRDATA == {5'h00, bq_q[26:0]})
        else $error("batch quantity readback differs");
    AST_OVF_NOTE: assert property ($rose(OVERFLOW_ERR) |-> pol_q == 2'b10)
        else $error("overflow flagged outside notify policy");
    AST_UNMAPPED: assert property ((dp_rd_q && dp_addr_q == 32'h28)
        |-> HRDATA == 32'h0)
        else $error("unmapped read not zero");
endmodule // ftb_top_checker
